// File: core/tftcl_consts.svh
// Register offsets, field positions, reset values and framing constants.
// Assumes inclusion by every design file that decodes registers or frames.
`ifndef TFTCL_CONSTS_SVH
`define TFTCL_CONSTS_SVH
`define TFTCL_ADDR_MASTER_CFG 8'h02
`define TFTCL_ADDR_FRAMER_CTRL 8'h10
`define TFTCL_ADDR_INFO 8'h14
`define TFTCL_ADDR_BPV_CNT 8'h16
`define TFTCL_FC_RESET 16'h0000
`define TFTCL_FC_MASK 16'h7fff
`define TFTCL_MC_RESET 16'h0000
`define TFTCL_MC_MASK 16'h0001
`define TFTCL_B_AIS 0
`define TFTCL_B_RAI 1
`define TFTCL_B_PT 2
`define TFTCL_B_NAT_LO 3
`define TFTCL_B_NAT_HI 4
`define TFTCL_B_IDLE 5
`define TFTCL_B_LLB 6
`define TFTCL_B_DLB 7
`define TFTCL_B_CVE 8
`define TFTCL_B_PLB 14
`define TFTCL_B_STANDALONE 0
`define TFTCL_B_RESYNC 1
`define TFTCL_T3_BLK_LAST 7'h54
`define TFTCL_T3_BLKS_LAST 3'h7
`define TFTCL_T3_SUB_LAST 3'h6
`define TFTCL_E3_LAST 11'h5ff
`define TFTCL_E3_FAS 10'h3d0
`define TFTCL_E3_FAS_LAST 11'h009
`define TFTCL_E3_RAI_POS 11'h00a
`define TFTCL_E3_NAT_POS 11'h00b
`define TFTCL_F_PATTERN 4'h9
`define TFTCL_M_PATTERN 3'h2
`define TFTCL_ZRUN_MAX 3'h7
`define TFTCL_E3_CODE_ZEROS 3'h2
`define TFTCL_T3_CODE_ZEROS 3'h1
`define TFTCL_CNT_MAX 16'hffff
`endif

// File: core/tftcl_pkg.sv
// Types shared by the framer control design files.
// Assumes nothing of its surroundings.
package tftcl_pkg;
    typedef enum logic [1:0] {
        TFTCL_HUNT = 2'b01,
        TFTCL_LOCK = 2'b10
    } tftcl_rx_state_type;
    typedef enum logic [1:0] {
        TFTCL_NAT_ONE = 2'h0,
        TFTCL_NAT_HDLC = 2'h1,
        TFTCL_NAT_FEAC = 2'h2,
        TFTCL_NAT_ZERO = 2'h3
    } tftcl_nat_src_type;
endpackage : tftcl_pkg

// File: core/tftcl_rail_if.sv
// Positive and negative rail pair on the line clock.
// Assumes both rails change only on the line clock.
`timescale 1ns/1ps
`default_nettype none
interface tftcl_rail_if;
    logic pos;
    logic neg;
    modport src (output pos, output neg);
    modport snk (input pos, input neg);
endinterface : tftcl_rail_if
`default_nettype wire

// File: core/tftcl_sync2.sv
// Two-flop level synchroniser, one per bit.
// Assumes each bit is an independent level or a toggle.
`timescale 1ns/1ps
`default_nettype none
module tftcl_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end
endmodule : tftcl_sync2
`default_nettype wire

// File: core/tftcl_violation_detect.sv
// Bipolar and code violation detector on the receive rails.
// Assumes rails are synchronous to clk and reset is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "tftcl_consts.svh"
module tftcl_violation_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic e3Mode,
    input wire logic cvSelect,
    tftcl_rail_if.snk rail,
    output logic violEvent
);
    logic lastPol_r, haveMark_r, lastViolPol_r, haveViol_r;
    logic [2:0] zeroRun_r;
    logic mark, sameMark, codeword, bpvHit, cvHit;

    always_comb begin
        mark = rail.pos | rail.neg;
        sameMark = mark && haveMark_r && (rail.pos == lastPol_r);
        codeword = zeroRun_r >= (e3Mode ? `TFTCL_E3_CODE_ZEROS : `TFTCL_T3_CODE_ZEROS);
        bpvHit = sameMark && !codeword;
        cvHit = sameMark && haveViol_r && (rail.pos == lastViolPol_r);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastPol_r <= 1'b0;
            haveMark_r <= 1'b0;
            zeroRun_r <= 3'h0;
        end else if (mark) begin
            lastPol_r <= rail.pos;
            haveMark_r <= 1'b1;
            zeroRun_r <= 3'h0;
        end else if (zeroRun_r != `TFTCL_ZRUN_MAX) begin
            zeroRun_r <= zeroRun_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastViolPol_r <= 1'b0;
            haveViol_r <= 1'b0;
            violEvent <= 1'b0;
        end else begin
            if (sameMark) begin
                lastViolPol_r <= rail.pos;
                haveViol_r <= 1'b1;
            end
            violEvent <= (e3Mode && cvSelect) ? cvHit : bpvHit;
        end
    end

    a_bpv_same_pol: assert property (@(posedge clk) disable iff (!rst_n)
        !(e3Mode && cvSelect) && mark && haveMark_r && rail.pos == lastPol_r && !codeword |=> violEvent)
        else $error("bipolar violation not reported");
    a_cv_select_pair: assert property (@(posedge clk) disable iff (!rst_n)
        e3Mode && cvSelect |=> violEvent == $past(cvHit))
        else $error("code violation event mismatch");
endmodule : tftcl_violation_detect
`default_nettype wire

// File: core/tftcl_framer_ctrl.sv
// T3/E3 formatter control, loopback routing and violation counting.
// Assumes lineRxClock runs free; rails and payload inputs are on that clock.
`timescale 1ns/1ps
`default_nettype none
`include "tftcl_consts.svh"
module tftcl_framer_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hostSel,
    input wire logic hostWrite,
    input wire logic [7:0] hostAddr,
    input wire logic [15:0] hostWrData,
    output logic [15:0] hostRdData,
    output logic hostRdValid,
    input wire logic e3ModePin,
    input wire logic lineRxClock,
    input wire logic lineRxPositive,
    input wire logic lineRxNegative,
    output logic lineTxClock,
    output logic lineTxPositive,
    output logic lineTxNegative,
    input wire logic sysTxData,
    input wire logic muxTxData,
    input wire logic hdlcNationalBit,
    input wire logic feacNationalBit,
    output logic sysRxData,
    output logic rxNationalBit,
    output logic rxNationalStrobe
);
    // Host clock domain
    logic [15:0] framerCtrl_r, masterCfg_r, bpvCount_r;
    logic resyncTgl_r, violPrev_r, violRise;
    logic [2:0] backSync;

    // Line clock domain
    logic rstLink_n;
    logic [18:0] cfgL;
    logic resyncPrevL_r, resyncReqL;
    logic e3L, aisL, raiL, ptL, idleL, llbL, dlbL, plbL, cveL, standaloneL;
    tftcl_pkg::tftcl_nat_src_type natSrcL;
    logic [6:0] blkPos_r;
    logic [2:0] blk_r, sub_r;
    logic [10:0] e3Pos_r;
    logic altBit_r, parityAcc_r, parityPrev_r;
    logic [1:0] idleCnt_r;
    logic txPol_r, loopPol_r, loopPos_r, loopNeg_r;
    logic ohPos, xPos, pPos, mPos, fPos, cPos, frameT3Bit;
    logic payloadSrc, natTx, fmtNorm, fmtAis, fmtLine, payloadSlot;
    logic violL_r, violEvent, rxBit, rxNat_r, violTgl_r;
    logic [9:0] fasShift_r;
    logic [10:0] rxPos_r;
    tftcl_pkg::tftcl_rx_state_type rxState_r;

    tftcl_rail_if rxRail ();

    // ---------------- Host registers ----------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            framerCtrl_r <= `TFTCL_FC_RESET;
            masterCfg_r <= `TFTCL_MC_RESET;
        end else if (hostSel && hostWrite) begin
            if (hostAddr == `TFTCL_ADDR_FRAMER_CTRL) begin
                framerCtrl_r <= hostWrData & `TFTCL_FC_MASK;
            end
            if (hostAddr == `TFTCL_ADDR_MASTER_CFG) begin
                masterCfg_r <= hostWrData & `TFTCL_MC_MASK;
            end
        end
    end

    // Resync request is a write of one to its bit; carried over as a toggle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resyncTgl_r <= 1'b0;
        end else if (hostSel && hostWrite && hostAddr == `TFTCL_ADDR_MASTER_CFG
                     && hostWrData[`TFTCL_B_RESYNC]) begin
            resyncTgl_r <= ~resyncTgl_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hostRdData <= 16'h0000;
            hostRdValid <= 1'b0;
        end else begin
            hostRdValid <= hostSel && !hostWrite;
            if (hostSel && !hostWrite) begin
                case (hostAddr)
                    `TFTCL_ADDR_FRAMER_CTRL: hostRdData <= framerCtrl_r;
                    `TFTCL_ADDR_MASTER_CFG: hostRdData <= masterCfg_r;
                    `TFTCL_ADDR_INFO: hostRdData <= {14'h0000, backSync[1], backSync[0]};
                    `TFTCL_ADDR_BPV_CNT: hostRdData <= bpvCount_r;
                    default: hostRdData <= 16'h0000;
                endcase
            end
        end
    end

    // Violation counter saturates; a read clears it, but an event in that cycle still counts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            violPrev_r <= 1'b0;
            bpvCount_r <= 16'h0000;
        end else begin
            violPrev_r <= backSync[2];
            if (hostSel && !hostWrite && hostAddr == `TFTCL_ADDR_BPV_CNT) begin
                bpvCount_r <= {15'h0000, violRise};
            end else if (violRise && bpvCount_r != `TFTCL_CNT_MAX) begin
                bpvCount_r <= bpvCount_r + 16'h0001;
            end
        end
    end

    assign violRise = backSync[2] ^ violPrev_r;

    tftcl_sync2 #(.WIDTH(3)) u_backSync (
        .clk(clk),
        .d({violTgl_r, rxNat_r, rxState_r == tftcl_pkg::TFTCL_LOCK}),
        .q(backSync)
    );

    // ---------------- Crossing into the line domain ----------------
    tftcl_sync2 #(.WIDTH(1)) u_rstSync (
        .clk(lineRxClock),
        .d(rst_n),
        .q(rstLink_n)
    );

    tftcl_sync2 #(.WIDTH(19)) u_cfgSync (
        .clk(lineRxClock),
        .d({resyncTgl_r, e3ModePin, masterCfg_r[`TFTCL_B_STANDALONE], framerCtrl_r}),
        .q(cfgL)
    );

    always_comb begin
        e3L = cfgL[17];
        standaloneL = cfgL[16];
        aisL = cfgL[`TFTCL_B_AIS];
        raiL = cfgL[`TFTCL_B_RAI];
        ptL = cfgL[`TFTCL_B_PT];
        natSrcL = tftcl_pkg::tftcl_nat_src_type'(cfgL[`TFTCL_B_NAT_HI:`TFTCL_B_NAT_LO]);
        idleL = cfgL[`TFTCL_B_IDLE] && !e3L;
        llbL = cfgL[`TFTCL_B_LLB];
        dlbL = cfgL[`TFTCL_B_DLB];
        cveL = cfgL[`TFTCL_B_CVE] && e3L;
        plbL = cfgL[`TFTCL_B_PLB];
        resyncReqL = cfgL[18] ^ resyncPrevL_r;
    end

    // ---------------- Frame position counters ----------------
    always_ff @(posedge lineRxClock) begin
        if (!rstLink_n) begin
            blkPos_r <= 7'h00;
            blk_r <= 3'h0;
            sub_r <= 3'h0;
            e3Pos_r <= 11'h000;
        end else begin
            e3Pos_r <= (e3Pos_r == `TFTCL_E3_LAST) ? 11'h000 : e3Pos_r + 11'h001;
            if (blkPos_r != `TFTCL_T3_BLK_LAST) begin
                blkPos_r <= blkPos_r + 7'h01;
            end else begin
                blkPos_r <= 7'h00;
                if (blk_r != `TFTCL_T3_BLKS_LAST) begin
                    blk_r <= blk_r + 3'h1;
                end else begin
                    blk_r <= 3'h0;
                    sub_r <= (sub_r == `TFTCL_T3_SUB_LAST) ? 3'h0 : sub_r + 3'h1;
                end
            end
        end
    end

    // ---------------- Formatter bit selection ----------------
    always_comb begin
        ohPos = blkPos_r == 7'h00;
        xPos = ohPos && blk_r == 3'h0 && sub_r < 3'h2;
        pPos = ohPos && blk_r == 3'h0 && (sub_r == 3'h2 || sub_r == 3'h3);
        mPos = ohPos && blk_r == 3'h0 && sub_r > 3'h3;
        fPos = ohPos && blk_r[0];
        cPos = ohPos && blk_r != 3'h0 && !blk_r[0];
        case (1'b1)
            pPos: frameT3Bit = parityPrev_r;
            mPos: frameT3Bit = 1'(`TFTCL_M_PATTERN >> (3'h6 - sub_r));
            fPos: frameT3Bit = 1'(`TFTCL_F_PATTERN >> (2'h3 - blk_r[2:1]));
            default: frameT3Bit = 1'b0;
        endcase
        if (plbL) begin
            payloadSrc = sysRxData;
        end else begin
            payloadSrc = standaloneL ? sysTxData : muxTxData;
        end
        case (natSrcL)
            tftcl_pkg::TFTCL_NAT_ONE: natTx = 1'b1;
            tftcl_pkg::TFTCL_NAT_HDLC: natTx = hdlcNationalBit;
            tftcl_pkg::TFTCL_NAT_FEAC: natTx = feacNationalBit;
            default: natTx = 1'b0;
        endcase
        payloadSlot = e3L ? (e3Pos_r > `TFTCL_E3_NAT_POS) : !ohPos;
        // No C-bit parity input reaches this path, so AIS is alike in both parity modes
        if (e3L) begin
            fmtAis = 1'b1;
        end else if (xPos) begin
            fmtAis = 1'b1;
        end else if (cPos) begin
            fmtAis = 1'b0;
        end else if (ohPos) begin
            fmtAis = frameT3Bit;
        end else begin
            fmtAis = altBit_r;
        end
        if (ptL) begin
            fmtNorm = payloadSrc;
        end else if (e3L) begin
            if (e3Pos_r <= `TFTCL_E3_FAS_LAST) begin
                fmtNorm = 1'(`TFTCL_E3_FAS >> (4'h9 - e3Pos_r[3:0]));
            end else if (e3Pos_r == `TFTCL_E3_RAI_POS) begin
                fmtNorm = raiL;
            end else if (e3Pos_r == `TFTCL_E3_NAT_POS) begin
                fmtNorm = natTx;
            end else begin
                fmtNorm = payloadSrc;
            end
        end else if (xPos) begin
            fmtNorm = idleL ? 1'b1 : !raiL;
        end else if (cPos) begin
            fmtNorm = idleL ? (sub_r != 3'h2) : payloadSrc;
        end else if (ohPos) begin
            fmtNorm = frameT3Bit;
        end else begin
            fmtNorm = idleL ? !idleCnt_r[1] : payloadSrc;
        end
        fmtLine = aisL ? fmtAis : fmtNorm;
    end

    // Payload pattern state and parity over the transmitted payload
    always_ff @(posedge lineRxClock) begin
        if (!rstLink_n) begin
            altBit_r <= 1'b1;
            idleCnt_r <= 2'h0;
            parityAcc_r <= 1'b0;
            parityPrev_r <= 1'b0;
        end else begin
            if (payloadSlot) begin
                altBit_r <= ~altBit_r;
                idleCnt_r <= idleCnt_r + 2'h1;
            end
            if (!e3L && sub_r == `TFTCL_T3_SUB_LAST && blk_r == `TFTCL_T3_BLKS_LAST
                && blkPos_r == `TFTCL_T3_BLK_LAST) begin
                parityPrev_r <= parityAcc_r ^ fmtLine;
                parityAcc_r <= 1'b0;
            end else if (!ohPos) begin
                parityAcc_r <= parityAcc_r ^ fmtLine;
            end
        end
    end

    // ---------------- Line encoders and loopback routing ----------------
    assign lineTxClock = lineRxClock;

    always_ff @(posedge lineRxClock) begin
        if (!rstLink_n) begin
            txPol_r <= 1'b0;
            lineTxPositive <= 1'b0;
            lineTxNegative <= 1'b0;
        end else if (llbL) begin
            lineTxPositive <= lineRxPositive;
            lineTxNegative <= lineRxNegative;
        end else begin
            if (fmtLine) begin
                txPol_r <= ~txPol_r;
            end
            lineTxPositive <= fmtLine && !txPol_r;
            lineTxNegative <= fmtLine && txPol_r;
        end
    end

    // Looped copy never carries AIS so the receive framer sees real traffic
    always_ff @(posedge lineRxClock) begin
        if (!rstLink_n) begin
            loopPol_r <= 1'b0;
            loopPos_r <= 1'b0;
            loopNeg_r <= 1'b0;
        end else begin
            if (fmtNorm) begin
                loopPol_r <= ~loopPol_r;
            end
            loopPos_r <= fmtNorm && !loopPol_r;
            loopNeg_r <= fmtNorm && loopPol_r;
        end
    end

    assign rxRail.pos = dlbL ? loopPos_r : lineRxPositive;
    assign rxRail.neg = dlbL ? loopNeg_r : lineRxNegative;
    assign rxBit = rxRail.pos | rxRail.neg;

    tftcl_violation_detect u_viol (
        .clk(lineRxClock),
        .rst_n(rstLink_n),
        .e3Mode(e3L),
        .cvSelect(cveL),
        .rail(rxRail),
        .violEvent(violEvent)
    );

    always_ff @(posedge lineRxClock) begin
        if (!rstLink_n) begin
            violTgl_r <= 1'b0;
            violL_r <= 1'b0;
        end else begin
            violL_r <= violEvent;
            if (violEvent) begin
                violTgl_r <= ~violTgl_r;
            end
        end
    end

    // ---------------- Receive framer (E3 alignment) ----------------
    always_ff @(posedge lineRxClock) begin
        if (!rstLink_n) begin
            resyncPrevL_r <= 1'b0;
            fasShift_r <= 10'h000;
            rxPos_r <= 11'h000;
            rxState_r <= tftcl_pkg::TFTCL_HUNT;
            rxNat_r <= 1'b0;
            rxNationalBit <= 1'b0;
            rxNationalStrobe <= 1'b0;
            sysRxData <= 1'b0;
        end else begin
            resyncPrevL_r <= cfgL[18];
            fasShift_r <= {fasShift_r[8:0], rxBit};
            sysRxData <= rxBit;
            rxPos_r <= (rxPos_r == `TFTCL_E3_LAST) ? 11'h000 : rxPos_r + 11'h001;
            rxNationalStrobe <= 1'b0;
            case (rxState_r)
                tftcl_pkg::TFTCL_HUNT: begin
                    if (e3L && !resyncReqL && {fasShift_r[8:0], rxBit} == `TFTCL_E3_FAS) begin
                        rxState_r <= tftcl_pkg::TFTCL_LOCK;
                        rxPos_r <= `TFTCL_E3_RAI_POS;
                    end
                end
                tftcl_pkg::TFTCL_LOCK: begin
                    if (resyncReqL || !e3L) begin
                        rxState_r <= tftcl_pkg::TFTCL_HUNT;
                    end else if (rxPos_r == `TFTCL_E3_FAS_LAST
                                 && {fasShift_r[8:0], rxBit} != `TFTCL_E3_FAS) begin
                        rxState_r <= tftcl_pkg::TFTCL_HUNT;
                    end
                    if (rxPos_r == `TFTCL_E3_NAT_POS) begin
                        rxNat_r <= rxBit;
                        rxNationalBit <= rxBit;
                        rxNationalStrobe <= 1'b1;
                    end
                end
                default: rxState_r <= tftcl_pkg::TFTCL_HUNT;
            endcase
        end
    end

    // ---------------- Checks ----------------
    a_t3_ais_x: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        !e3L && aisL && !llbL && xPos |=> lineTxPositive || lineTxNegative)
        else $error("T3 AIS X bit not sent as one");
    a_t3_ais_cbit: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        !e3L && aisL && !llbL && cPos |=> !lineTxPositive && !lineTxNegative)
        else $error("T3 AIS C bit not zero");
    a_e3_ais_ones: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        e3L && aisL && !llbL |=> lineTxPositive != lineTxNegative)
        else $error("E3 AIS not all ones");
    a_t3_rai_x: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        !e3L && !aisL && !idleL && !ptL && xPos |-> fmtLine == !raiL)
        else $error("T3 X bits disagree with remote alarm");
    a_e3_rai_bit: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        e3L && !aisL && !ptL && e3Pos_r == `TFTCL_E3_RAI_POS |-> fmtLine == raiL)
        else $error("E3 remote alarm bit wrong");
    a_pass_thru: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        ptL && !aisL |-> fmtLine == payloadSrc)
        else $error("Overhead inserted during pass-through");
    a_nat_source: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        e3L && !aisL && !ptL && e3Pos_r == `TFTCL_E3_NAT_POS && natSrcL == tftcl_pkg::TFTCL_NAT_ZERO
        |-> !fmtLine)
        else $error("National bit not forced to zero");
    a_idle_c3: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        !e3L && idleL && !aisL && !ptL && cPos && sub_r == 3'h2 |-> !fmtLine)
        else $error("Idle subframe 3 C bit not zero");
    a_line_loop: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        llbL ##1 llbL |-> lineTxPositive == $past(lineRxPositive) && lineTxNegative == $past(lineRxNegative))
        else $error("Line loopback rails not forwarded");
    a_diag_loop: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        dlbL ##1 dlbL |-> (rxRail.pos | rxRail.neg) == $past(fmtNorm))
        else $error("Diagnostic loopback not feeding receive side");
    a_resync_hunt: assert property (@(posedge lineRxClock) disable iff (!rstLink_n)
        resyncReqL |=> rxState_r == tftcl_pkg::TFTCL_HUNT)
        else $error("Resync did not restart hunting");
    a_viol_count: assert property (@(posedge clk) disable iff (!rst_n)
        violRise && !hostSel && bpvCount_r != `TFTCL_CNT_MAX |=> bpvCount_r == $past(bpvCount_r) + 16'h0001)
        else $error("Violation not counted");
endmodule : tftcl_framer_ctrl
`default_nettype wire

// File: verification/tftcl_line_model.sv
// Line interface model: free-running receive clock and AMI rails.
// Assumes the bench picks marks or spaces through sendMarks.
`timescale 1ns/1ps
`default_nettype none
module tftcl_line_model (
    output logic lineRxClock,
    output logic lineRxPositive,
    output logic lineRxNegative,
    input wire logic sendMarks,
    input wire logic sameSign
);
    logic polarity_r;
    initial begin
        lineRxClock = 1'b0;
        lineRxPositive = 1'b0;
        lineRxNegative = 1'b0;
        polarity_r = 1'b0;
        #7;
        forever #24 lineRxClock = ~lineRxClock;
    end
    // Alternating polarity keeps the stream clean; sameSign repeats it to make violations
    always @(posedge lineRxClock) begin
        lineRxPositive <= #2 sendMarks & ~polarity_r;
        lineRxNegative <= #2 sendMarks & polarity_r;
        polarity_r <= polarity_r ^ (sendMarks & ~sameSign);
    end
endmodule : tftcl_line_model
`default_nettype wire

// File: verification/tb_t3e3_framer_tx_control_loopback.sv
// Bench for the framer control block: register access and line output.
// Assumes the line model drives the receive side.
`timescale 1ns/1ps
`default_nettype none
module tb_t3e3_framer_tx_control_loopback;
    logic clk, rst_n, hostSel, hostWrite, e3ModePin, sendMarks, zero, hostRdValid;
    logic sameSign, standBit, rxNatBit;
    logic [7:0] hostAddr;
    logic [15:0] hostWrData, hostRdData;
    logic lineRxClock, lineRxPositive, lineRxNegative, lineTxClock, lineTxPositive, lineTxNegative;
    int n_fail, checks;
    tftcl_line_model line (.lineRxClock(lineRxClock), .lineRxPositive(lineRxPositive),
        .lineRxNegative(lineRxNegative), .sendMarks(sendMarks), .sameSign(sameSign));
    tftcl_framer_ctrl DUT (.clk(clk), .rst_n(rst_n), .hostSel(hostSel), .hostWrite(hostWrite),
        .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
        .hostRdValid(hostRdValid), .e3ModePin(e3ModePin), .lineRxClock(lineRxClock),
        .lineRxPositive(lineRxPositive), .lineRxNegative(lineRxNegative),
        .lineTxClock(lineTxClock), .lineTxPositive(lineTxPositive),
        .lineTxNegative(lineTxNegative), .sysTxData(standBit), .muxTxData(zero),
        .hdlcNationalBit(zero), .feacNationalBit(zero), .sysRxData(),
        .rxNationalBit(rxNatBit), .rxNationalStrobe());
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic compare(input string what, input logic [15:0] expv, input logic [15:0] got);
        checks++;
        if (got !== expv) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, expv, got);
        end
    endtask : compare
    task automatic host_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        #2 hostSel = 1'b1;
        hostWrite = 1'b1;
        hostAddr = a;
        hostWrData = d;
        @(posedge clk);
        #2 hostSel = 1'b0;
        hostWrite = 1'b0;
    endtask : host_write
    task automatic cfg(input logic [15:0] d);
        host_write(8'h10, d);
        repeat (8) @(posedge lineTxClock);
    endtask : cfg
    task automatic host_read(input logic [7:0] a, input logic [15:0] expv);
        @(posedge clk);
        #2 hostSel = 1'b1;
        hostAddr = a;
        @(posedge clk);
        #2 hostSel = 1'b0;
        compare("read valid", 16'h0001, {15'h0000, hostRdValid});
        compare("read data", expv, hostRdData);
    endtask : host_read
    // Counts marks on the transmit rails over n bit periods
    task automatic count_marks(input int n, input logic [15:0] expv);
        logic [15:0] cnt;
        cnt = 16'h0000;
        repeat (n) begin
            @(negedge lineTxClock);
            if ((lineTxPositive | lineTxNegative) === 1'b1) cnt++;
        end
        compare("mark count", expv, cnt);
    endtask : count_marks
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #2300000;
        n_fail++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0; hostSel = 1'b0; hostWrite = 1'b0; hostAddr = 8'h00;
        hostWrData = 16'h0000; e3ModePin = 1'b1; sendMarks = 1'b0; zero = 1'b0;
        sameSign = 1'b0; standBit = 1'b1;
        n_fail = 0; checks = 0;
        repeat (10) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge lineRxClock);
        host_read(8'h10, 16'h0000);
        cfg(16'hffff);
        host_read(8'h10, 16'h7fff);
        host_read(8'h30, 16'h0000);
        cfg(16'h0001);
        count_marks(40, 16'd40);
        cfg(16'h0081);
        count_marks(40, 16'd40);
        cfg(16'h0004);
        count_marks(1536, 16'd0);
        cfg(16'h0040);
        count_marks(60, 16'd0);
        sendMarks = 1'b1;
        repeat (4) @(posedge lineRxClock);
        count_marks(40, 16'd40);
        cfg(16'h4004);
        count_marks(40, 16'd40);
        // Five same-sign marks after an opposite one give four violations
        @(posedge lineRxClock);
        #2 sameSign = 1'b1;
        repeat (5) @(posedge lineRxClock);
        #2 sameSign = 1'b0;
        sendMarks = 1'b0;
        repeat (10) @(posedge lineRxClock);
        host_read(8'h16, 16'h0004);
        host_read(8'h16, 16'h0000);
        cfg(16'h0000);
        count_marks(1536, 16'd6);
        cfg(16'h0002);
        count_marks(1536, 16'd7);
        cfg(16'h0018);
        count_marks(1536, 16'd5);
        cfg(16'h0020);
        count_marks(1536, 16'd6);
        cfg(16'h0080);
        count_marks(1536, 16'd6);
        repeat (40) @(posedge lineRxClock);
        host_read(8'h14, 16'h0003);
        compare("national bit", 16'h0001, {15'h0000, rxNatBit});
        host_write(8'h02, 16'h0003);
        host_read(8'h02, 16'h0001);
        cfg(16'h0004);
        count_marks(40, 16'd40);
        host_write(8'h02, 16'h0000);
        // T3: wait two multiframes so the P bits reflect a clean frame
        e3ModePin = 1'b0;
        cfg(16'h0002);
        repeat (9520) @(posedge lineRxClock);
        count_marks(4760, 16'd15);
        cfg(16'h0018);
        count_marks(4760, 16'd17);
        cfg(16'h0001);
        repeat (9520) @(posedge lineRxClock);
        count_marks(4760, 16'd2369);
        give_verdict();
    end
endmodule : tb_t3e3_framer_tx_control_loopback
`default_nettype wire
